// ### pkg/bhps_defs.svh
// constants of the byte host port with shadow registers
`ifndef BHPS_DEFS_SVH
`define BHPS_DEFS_SVH
`define BHPS_NUM_REGS    64
`define BHPS_IDX_W       6
`define BHPS_BYTE_W      8
`define BHPS_QUAD_W      32
`define BHPS_SEL_W       2
`define BHPS_LAST_BYTE   2'h3
`define BHPS_QUAD_RST    32'h0000_0000
`define BHPS_BYTE_RST    8'h00
`define BHPS_IDX_RST     6'h00
`define BHPS_STROBE_IDLE 1'b1
`endif

// ### pkg/bhps_pkg.sv
// types of the byte host port with shadow registers
`include "bhps_defs.svh"
package bhps_pkg;

   typedef enum logic [1:0] {
      st_idle,
      st_fetch,
      st_busy
   } bhps_fsm_type;

   typedef struct packed {
      logic                      cs_s1;
      logic                      cs_s2;
      logic                      rd_s1;
      logic                      rd_s2;
      logic                      wr_s1;
      logic                      wr_s2;
      bhps_fsm_type              fsm;
      logic [`BHPS_IDX_W-1:0]    idx;
      logic [`BHPS_QUAD_W-1:0]   rshadow;
      logic [`BHPS_QUAD_W-1:0]   wshadow;
      logic [`BHPS_BYTE_W-1:0]   dout;
      logic                      oe;
      logic                      cval;
      logic [`BHPS_IDX_W-1:0]    cidx;
      logic [`BHPS_QUAD_W-1:0]   cdata;
   } bhps_state_type;

endpackage

// ### design/bhps_regfile.sv
// internal quadlet register space with registered read data
`timescale 1ns/1ps
`include "bhps_defs.svh"
module bhps_regfile
   import bhps_pkg::*;
#(
   parameter int DEPTH  = `BHPS_NUM_REGS,
   parameter int WIDTH  = `BHPS_QUAD_W,
   parameter int ADDR_W = `BHPS_IDX_W
)
(
   // clock and control
   input  wire logic              mclk_i,
   input  wire logic              ce_i,
   // write port
   input  wire logic              we_i,
   input  wire logic [ADDR_W-1:0] waddr_i,
   input  wire logic [WIDTH-1:0]  wdata_i,
   // read port
   input  wire logic              re_i,
   input  wire logic [ADDR_W-1:0] raddr_i,
   output logic      [WIDTH-1:0]  rdata_o
);

   logic [WIDTH-1:0] mem_reg [DEPTH];

   //--------------------------------------------------------------
   // storage and read register
   //--------------------------------------------------------------
   always_ff @(posedge mclk_i)
   begin
      if (ce_i)
      begin
         if (we_i)
         begin
            mem_reg[waddr_i] <= wdata_i;
         end
         if (re_i)
         begin
            rdata_o <= mem_reg[raddr_i];
         end
      end
   end

endmodule

// ### design/bhps_port.sv
// byte-wide host port with read and write shadow registers
//
// Summary of operation
// - sixty-four internal quadlet registers are reachable
// - byte space of 256 locations, 8 lines
// - internal transfers always move whole quadlets
// - two low lines pick read shadow byte
// - six upper lines give register index
// - read with update snapshots register, shows byte
// - plain reads leave read shadow unchanged
// - write shadow commits whole quadlet in one tick
// - two low lines pick write shadow byte
// - one write cycle loads one byte only
// - write with update commits shadow to register
// - unwritten shadow bytes keep their old values
// - access starts when select and strobe low
// - host strobes resampled before use
`timescale 1ns/1ps
`include "bhps_defs.svh"
module bhps_port
   import bhps_pkg::*;
(
   // clock, reset and enable
   input  wire logic                     mclk_i,
   input  wire logic                     rst_i,
   input  wire logic                     ce_i,
   // host control strobes
   input  wire logic                     port_select_low_i,
   input  wire logic                     read_strobe_low_i,
   input  wire logic                     write_strobe_low_i,
   // host address lines
   input  wire logic                     byte_select_low_i,
   input  wire logic                     byte_select_high_i,
   input  wire logic [`BHPS_IDX_W-1:0]   register_index_lines_i,
   input  wire logic                     snapshot_update_line_i,
   // host data bus
   input  wire logic [`BHPS_BYTE_W-1:0]  host_byte_bus_i,
   output logic      [`BHPS_BYTE_W-1:0]  host_byte_bus_o,
   output logic                          host_byte_bus_oe_o,
   // commit notice towards internal logic
   output logic                          commit_valid_o,
   output logic      [`BHPS_IDX_W-1:0]   commit_index_o,
   output logic      [`BHPS_QUAD_W-1:0]  commit_data_o
);

   localparam bhps_state_type ST_RST = '{
      cs_s1   : `BHPS_STROBE_IDLE,
      cs_s2   : `BHPS_STROBE_IDLE,
      rd_s1   : `BHPS_STROBE_IDLE,
      rd_s2   : `BHPS_STROBE_IDLE,
      wr_s1   : `BHPS_STROBE_IDLE,
      wr_s2   : `BHPS_STROBE_IDLE,
      fsm     : st_idle,
      idx     : `BHPS_IDX_RST,
      rshadow : `BHPS_QUAD_RST,
      wshadow : `BHPS_QUAD_RST,
      dout    : `BHPS_BYTE_RST,
      oe      : 1'b0,
      cval    : 1'b0,
      cidx    : `BHPS_IDX_RST,
      cdata   : `BHPS_QUAD_RST
   };

   bhps_state_type                st_reg;
   bhps_state_type                st_next;
   logic                          rd_act;
   logic                          wr_act;
   logic                          acc_start;
   logic                          mem_re;
   logic                          mem_we;
   logic [`BHPS_QUAD_W-1:0]       mem_q;
   logic [`BHPS_SEL_W-1:0]        byte_sel;
   logic [`BHPS_SEL_W-1:0]        lane;

   //--------------------------------------------------------------
   // internal register space
   //--------------------------------------------------------------
   bhps_regfile #(
      .DEPTH  (`BHPS_NUM_REGS),
      .WIDTH  (`BHPS_QUAD_W),
      .ADDR_W (`BHPS_IDX_W)
   ) u_regfile (
      .mclk_i  (mclk_i),
      .ce_i    (ce_i),
      .we_i    (mem_we),
      .waddr_i (st_next.cidx),
      .wdata_i (st_next.cdata),
      .re_i    (mem_re),
      .raddr_i (register_index_lines_i),
      .rdata_o (mem_q)
   );

   //--------------------------------------------------------------
   // next state
   //--------------------------------------------------------------
   always_comb
   begin
      st_next  = st_reg;
      mem_re   = 1'b0;
      mem_we   = 1'b0;
      byte_sel = {byte_select_high_i, byte_select_low_i};
      // byte 0 is the most significant lane
      lane     = `BHPS_LAST_BYTE - byte_sel;
      st_next.cs_s1 = port_select_low_i;
      st_next.cs_s2 = st_reg.cs_s1;
      st_next.rd_s1 = read_strobe_low_i;
      st_next.rd_s2 = st_reg.rd_s1;
      st_next.wr_s1 = write_strobe_low_i;
      st_next.wr_s2 = st_reg.wr_s1;
      // access level once select and a strobe are both low
      rd_act    = !st_reg.cs_s2 && !st_reg.rd_s2;
      wr_act    = !st_reg.cs_s2 && !st_reg.wr_s2;
      acc_start = (st_reg.fsm == st_idle) && (rd_act || wr_act);
      st_next.cval = 1'b0;
      case (st_reg.fsm)
         st_idle:
         begin
            if (rd_act)
            begin
               st_next.idx = register_index_lines_i;
               if (snapshot_update_line_i)
               begin
                  mem_re      = 1'b1;
                  st_next.fsm = st_fetch;
               end
               else
               begin
                  st_next.fsm = st_busy;
               end
            end
            else if (wr_act)
            begin
               st_next.idx = register_index_lines_i;
               // one lane loaded, others kept
               st_next.wshadow[lane*`BHPS_BYTE_W +: `BHPS_BYTE_W] =
                  host_byte_bus_i;
               if (snapshot_update_line_i)
               begin
                  st_next.cval  = 1'b1;
                  st_next.cidx  = register_index_lines_i;
                  st_next.cdata = st_next.wshadow;
                  mem_we        = 1'b1;
               end
               st_next.fsm = st_busy;
            end
         end
         st_fetch:
         begin
            st_next.rshadow = mem_q;
            st_next.fsm     = st_busy;
         end
         st_busy:
         begin
            // wait for the host to end the access
            if (!rd_act && !wr_act)
            begin
               st_next.fsm = st_idle;
            end
         end
         default:
         begin
            st_next.fsm = st_idle;
         end
      endcase
      // byte follows the select lines throughout the read
      st_next.dout = st_next.rshadow[lane*`BHPS_BYTE_W +: `BHPS_BYTE_W];
      st_next.oe   = rd_act && (st_next.fsm != st_fetch);
   end

   //--------------------------------------------------------------
   // state register
   //--------------------------------------------------------------
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         st_reg <= ST_RST;
      end
      else if (ce_i)
      begin
         st_reg <= st_next;
      end
   end

   //--------------------------------------------------------------
   // outputs
   //--------------------------------------------------------------
   assign host_byte_bus_o    = st_reg.dout;
   assign host_byte_bus_oe_o = st_reg.oe;
   assign commit_valid_o     = st_reg.cval;
   assign commit_index_o     = st_reg.cidx;
   assign commit_data_o      = st_reg.cdata;

   //--------------------------------------------------------------
   // checks
   //--------------------------------------------------------------
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (rst_i || !ce_i);

   snap_load_a: assert property (
      (st_reg.fsm == st_fetch) |=> (st_reg.rshadow == $past(mem_q)))
      else $error("snapshot not loaded from register space");

   snap_hold_a: assert property (
      (acc_start && rd_act && !snapshot_update_line_i)
      |=> $stable(st_reg.rshadow) [*2])
      else $error("read shadow changed on plain read");

   byte_out_a: assert property (
      (st_reg.fsm == st_busy && rd_act && $stable(st_reg.rshadow)
       && byte_sel == 2'h0)
      |=> (host_byte_bus_o == st_reg.rshadow[31:24]))
      else $error("byte 0 not shown from read shadow");

   commit_now_a: assert property (
      (acc_start && !rd_act && snapshot_update_line_i)
      |=> commit_valid_o && (commit_index_o == $past(register_index_lines_i)))
      else $error("update write did not commit");

   commit_data_a: assert property (
      commit_valid_o |-> (commit_data_o == st_reg.wshadow)
                         && !$past(commit_valid_o))
      else $error("commit data differs from write shadow");

   no_commit_a: assert property (
      !(acc_start && !rd_act && snapshot_update_line_i) |=> !commit_valid_o)
      else $error("commit without update write");

   one_lane_a: assert property (
      (acc_start && !rd_act)
      |=> ((st_reg.wshadow ^ $past(st_reg.wshadow)) &
           ~({24'h00_0000, 8'hff} << ($past(lane) * 8))) == 32'h0000_0000)
      else $error("write touched more than one byte");

   shadow_kept_a: assert property (
      !acc_start |=> $stable(st_reg.wshadow))
      else $error("write shadow changed outside a write");

   start_sync_a: assert property (
      acc_start |-> !$past(port_select_low_i, 2)
                    && (!$past(read_strobe_low_i, 2)
                        || !$past(write_strobe_low_i, 2)))
      else $error("access start without resampled strobes");

   oe_level_a: assert property (
      host_byte_bus_oe_o |-> !$past(port_select_low_i, 3)
                             && !$past(read_strobe_low_i, 3))
      else $error("bus driven without resampled read");

   reset_zero_a: assert property (disable iff (!ce_i)
      rst_i |=> (st_reg.rshadow == 32'h0000_0000)
                && (st_reg.wshadow == 32'h0000_0000))
      else $error("shadows not cleared by reset");

endmodule

// ### tb/bhps_host_model.sv
// host microcontroller model driving the byte host port
`timescale 1ns/1ps
module bhps_host_model
   import bhps_pkg::*;
(
   // clock
   input  wire logic       mclk_i,
   // strobes, address and data towards the port
   output logic            sel_low_o,
   output logic            rd_low_o,
   output logic            wr_low_o,
   output logic [1:0]      bsel_o,
   output logic [5:0]      idx_o,
   output logic            upd_o,
   output logic [7:0]      data_o,
   // answer from the port
   input  wire logic [7:0] data_i,
   input  wire logic       oe_i
);
   initial
   begin
      {sel_low_o, rd_low_o, wr_low_o} = 3'h7;
      {bsel_o, idx_o, upd_o} = 9'h000;
      data_o = 8'h5a;
   end

   task automatic wr_byte(input logic u, input logic [5:0] ix,
      input logic [1:0] bs, input logic [7:0] d);
      @(posedge mclk_i);
      sel_low_o <= 1'b0;
      wr_low_o  <= 1'b0;
      upd_o     <= u;
      idx_o     <= ix;
      bsel_o    <= bs;
      data_o    <= d;
      repeat (4) @(posedge mclk_i);
      sel_low_o <= 1'b1;
      wr_low_o  <= 1'b1;
      data_o    <= ~d;
      repeat (3) @(posedge mclk_i);
   endtask

   task automatic rd_quad(input logic u, input logic [5:0] ix,
      input logic [7:0] ord, output logic [31:0] q, output logic ok);
      logic [1:0] s;
      q = 32'h0000_0000;
      @(posedge mclk_i);
      rd_low_o <= 1'b0;
      upd_o    <= u;
      idx_o    <= ix;
      bsel_o   <= ord[7:6];
      @(posedge mclk_i);
      sel_low_o <= 1'b0;
      for (int n = 0; n < 20 && oe_i !== 1'b1; n++)
         @(negedge mclk_i);
      ok = (oe_i === 1'b1);
      for (int k = 0; k < 4; k++)
      begin
         s = ord[7-2*k -: 2];
         @(posedge mclk_i);
         bsel_o <= s;
         @(posedge mclk_i);
         @(negedge mclk_i);
         q[31-8*s -: 8] = data_i;
      end
      @(posedge mclk_i);
      sel_low_o <= 1'b1;
      rd_low_o  <= 1'b1;
      repeat (4) @(posedge mclk_i);
   endtask
endmodule

// ### tb/tb_top.sv
// self-checking bench of the byte host port
`timescale 1ns/1ps
module tb_top;
   import bhps_pkg::*;
   logic        mclk_i = 1'b0;
   logic        rst_i  = 1'b1;
   logic        sel_low, rd_low, wr_low, upd, oe, cval;
   logic [1:0]  bsel;
   logic [5:0]  idx, cidx, seen_idx;
   logic [7:0]  hdata, dout;
   logic [31:0] cdata, seen_data, ws_exp, rs_exp, lfsr_reg, r;
   logic [31:0] mem_exp [64];
   logic [7:0]  orders [4] = '{8'h1b, 8'he4, 8'h8d, 8'h72};
   int          seen_n, fail_count, check_count;

   always #2 mclk_i = ~mclk_i;

   bhps_port dut (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(1'b1),
      .port_select_low_i(sel_low), .read_strobe_low_i(rd_low),
      .write_strobe_low_i(wr_low), .byte_select_low_i(bsel[0]),
      .byte_select_high_i(bsel[1]), .register_index_lines_i(idx),
      .snapshot_update_line_i(upd), .host_byte_bus_i(hdata),
      .host_byte_bus_o(dout), .host_byte_bus_oe_o(oe),
      .commit_valid_o(cval), .commit_index_o(cidx),
      .commit_data_o(cdata));

   bhps_host_model host (.mclk_i(mclk_i), .sel_low_o(sel_low),
      .rd_low_o(rd_low), .wr_low_o(wr_low), .bsel_o(bsel), .idx_o(idx),
      .upd_o(upd), .data_o(hdata), .data_i(dout), .oe_i(oe));

   always @(posedge mclk_i)
   begin
      if (cval === 1'b1)
      begin
         seen_n++;
         seen_idx = cidx;
         seen_data = cdata;
      end
   end

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic logic [31:0] put_byte(input logic [31:0] q,
      input logic [1:0] bs, input logic [7:0] d);
      q[31-8*bs -: 8] = d;
      return q;
   endfunction

   task automatic check_val(input string name, input logic [31:0] seen_v,
      input logic [31:0] exp_v);
      check_count++;
      if (seen_v !== exp_v)
      begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp_v, seen_v);
      end
   endtask

   task automatic wr(input logic u, input logic [5:0] ix,
      input logic [1:0] bs);
      lfsr_reg = lfsr_next(lfsr_reg);
      ws_exp = put_byte(ws_exp, bs, lfsr_reg[7:0]);
      seen_n = 0;
      host.wr_byte(u, ix, bs, lfsr_reg[7:0]);
      check_val("commit count", seen_n, {31'h0000_0000, u});
      if (u)
      begin
         check_val("commit index", seen_idx, ix);
         check_val("commit data", seen_data, ws_exp);
         mem_exp[ix] = ws_exp;
      end
   endtask

   task automatic rd(input logic u, input logic [5:0] ix, input int oi);
      logic [31:0] q;
      logic        ok;
      if (u)
         rs_exp = mem_exp[ix];
      host.rd_quad(u, ix, orders[oi], q, ok);
      check_val("read enable", ok, 1'b1);
      check_val("read quad", q, rs_exp);
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial
   begin
      #40000;
      fail_count++;
      $display("watchdog expired");
      report_and_stop();
   end

   initial
   begin
      {ws_exp, rs_exp, lfsr_reg} = {64'h0000_0000_0000_0000, 32'h0000_3992};
      repeat (8) @(posedge mclk_i);
      rst_i <= 1'b0;
      @(negedge mclk_i);
      check_val("idle enable", oe, 1'b0);
      check_val("idle commit", cdata, 32'h0000_0000);
      rd(1'b0, 6'h00, 2);
      wr(1'b1, 6'h3f, 2'h3);
      rd(1'b1, 6'h3f, 0);
      wr(1'b1, 6'h00, 2'h0);
      rd(1'b1, 6'h00, 1);
      $display("test reset_and_edges done");
      for (int i = 0; i < 60; i++)
      begin
         lfsr_reg = lfsr_next(lfsr_reg);
         r = lfsr_reg;
         wr(r[8] & r[9], r[5:0], r[7:6]);
         if (r[8] & r[9])
            rd(1'b1, r[5:0], r[11:10]);
      end
      $display("test random_traffic done");
      rd(1'b1, 6'h3f, 2);
      wr(1'b0, 6'h3f, 2'h1);
      wr(1'b1, 6'h3f, 2'h2);
      rd(1'b0, 6'h00, 3);
      rd(1'b0, 6'h15, 1);
      $display("test shadow_hold done");
      report_and_stop();
   end
endmodule
